// ==== src/xpd_decode.sv ====
// Purpose: Extension bus address decode and peripheral enable register
// Assumes: CPU address valid with cpu_req, all synchronous to core_clk
// Notes: One registered target select per cycle
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module xpd_decode (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Mode
   input wire logic emu_mode,
   input wire logic power_down_req,
   // CPU access
   input wire logic cpu_req,
   input wire logic [23:0] cpu_addr,
   input wire logic cpu_byte,
   // Decode result
   output logic sel_ext_r,
   output logic sel_lower_ram_r,
   output logic sel_upper_ram_r,
   output logic sel_can1_r,
   output logic sel_can2_r,
   output logic sel_rtc_r,
   output logic [1:0] wait_states_r,
   output logic byte_access_r,
   // Side effects
   output logic [3:0] p4_gpio_release_r,
   output logic [3:0] seg_lines_r,
   output logic osc_stop_r,
   // AXI4-Lite write address
   input wire logic [15:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [15:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   function automatic logic in_range(input logic [23:0] a, input logic [23:0] lo,
                                     input logic [23:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction : in_range

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [4:0] periph_en_r, periph_en_nxt;
   logic global_en_r, global_en_nxt;
   logic osc_off_r, osc_off_nxt;
   logic aw_got_r, aw_got_nxt;
   logic w_got_r, w_got_nxt;
   logic [15:0] aw_addr_r, aw_addr_nxt;
   logic [31:0] w_data_r, w_data_nxt;
   logic [3:0] w_strb_r, w_strb_nxt;
   logic bvalid_nxt, rvalid_nxt;
   logic [1:0] bresp_nxt, rresp_nxt;
   logic [31:0] rdata_nxt;
   logic [4:0] eff_en;
   logic wr_fire;

   // Effective enables
   always_comb begin
      eff_en = emu_mode ? xpd_pkg::EMU_ALL_ENABLED : periph_en_r;
   end

   always_comb begin
      periph_en_nxt = periph_en_r;
      global_en_nxt = global_en_r;
      osc_off_nxt = osc_off_r;
      aw_got_nxt = aw_got_r;
      w_got_nxt = w_got_r;
      aw_addr_nxt = aw_addr_r;
      w_data_nxt = w_data_r;
      w_strb_nxt = w_strb_r;
      bvalid_nxt = s_axi_bvalid;
      bresp_nxt = s_axi_bresp;
      rvalid_nxt = s_axi_rvalid;
      rresp_nxt = s_axi_rresp;
      rdata_nxt = s_axi_rdata;
      wr_fire = 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_got_nxt = 1'b1;
         aw_addr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_got_nxt = 1'b1;
         w_data_nxt = s_axi_wdata;
         w_strb_nxt = s_axi_wstrb;
      end
      if (aw_got_r && w_got_r && !s_axi_bvalid) begin
         wr_fire = 1'b1;
         aw_got_nxt = 1'b0;
         w_got_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = 2'h0;
         if (aw_addr_r == xpd_pkg::OFS_PERIPH_ENABLE) begin
            if (!global_en_r && w_strb_r[0]) begin
               periph_en_nxt = w_data_r[4:0];
            end
         end else if (aw_addr_r == xpd_pkg::OFS_SYS_CONFIG) begin
            if (w_strb_r[0]) begin
               global_en_nxt = w_data_r[xpd_pkg::BIT_GLOBAL_EN];
            end
         end else if (aw_addr_r == xpd_pkg::OFS_STATUS) begin
            if (w_strb_r[0]) begin
               osc_off_nxt = w_data_r[xpd_pkg::BIT_CAL_OSC_OFF];
            end
         end else begin
            bresp_nxt = 2'h2;
         end
      end
      if (s_axi_bvalid && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = 2'h0;
         if (s_axi_araddr == xpd_pkg::OFS_PERIPH_ENABLE) begin
            rdata_nxt = {27'h0, eff_en};
         end else if (s_axi_araddr == xpd_pkg::OFS_SYS_CONFIG) begin
            rdata_nxt = {29'h0, global_en_r, 2'h0};
         end else if (s_axi_araddr == xpd_pkg::OFS_STATUS) begin
            rdata_nxt = {24'h0, osc_stop_r, seg_lines_r, 2'h0, osc_off_r};
         end else begin
            rdata_nxt = 32'h0;
            rresp_nxt = 2'h2;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         periph_en_r <= xpd_pkg::RST_PERIPH_ENABLE[4:0];
         global_en_r <= 1'b0;
         osc_off_r <= 1'b0;
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         aw_addr_r <= 16'h0;
         w_data_r <= 32'h0;
         w_strb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= 2'h0;
         s_axi_rdata <= 32'h0;
      end else if (clk_en) begin
         periph_en_r <= periph_en_nxt;
         global_en_r <= global_en_nxt;
         osc_off_r <= osc_off_nxt;
         aw_got_r <= aw_got_nxt;
         w_got_r <= w_got_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_data_r <= w_data_nxt;
         w_strb_r <= w_strb_nxt;
         s_axi_bvalid <= bvalid_nxt;
         s_axi_bresp <= bresp_nxt;
         s_axi_rvalid <= rvalid_nxt;
         s_axi_rresp <= rresp_nxt;
         s_axi_rdata <= rdata_nxt;
      end
   end

   // Ready only while the holding slot is free
   always_comb begin
      s_axi_awready = !aw_got_r && clk_en;
      s_axi_wready = !w_got_r && clk_en;
      s_axi_arready = !s_axi_rvalid && clk_en;
   end

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   xpd_pkg::xpd_target_e tgt;
   logic [1:0] ws_nxt;
   logic can_any;
   logic [3:0] rel_nxt;
   logic [3:0] seg_nxt;
   logic osc_nxt;

   always_comb begin
      can_any = eff_en[xpd_pkg::BIT_CAN1] || eff_en[xpd_pkg::BIT_CAN2];
      tgt = xpd_pkg::XPD_TGT_EXT;
      ws_nxt = xpd_pkg::XRAM_WAIT_STATES;
      if (global_en_r || emu_mode) begin
         if (in_range(cpu_addr, xpd_pkg::LOWER_RAM_LO, xpd_pkg::LOWER_RAM_HI)) begin
            if (eff_en[xpd_pkg::BIT_LOWER_RAM]) tgt = xpd_pkg::XPD_TGT_LOWER_RAM;
         end else if (in_range(cpu_addr, xpd_pkg::UPPER_RAM_LO, xpd_pkg::UPPER_RAM_HI)) begin
            if (eff_en[xpd_pkg::BIT_UPPER_RAM]) tgt = xpd_pkg::XPD_TGT_UPPER_RAM;
         end else if (in_range(cpu_addr, xpd_pkg::CAN1_LO, xpd_pkg::CAN1_HI)) begin
            if (eff_en[xpd_pkg::BIT_CAN1]) tgt = xpd_pkg::XPD_TGT_CAN1;
            else if (can_any) tgt = xpd_pkg::XPD_TGT_CAN2;
         end else if (in_range(cpu_addr, xpd_pkg::CAN2_LO, xpd_pkg::CAN2_HI)) begin
            if (eff_en[xpd_pkg::BIT_CAN2]) tgt = xpd_pkg::XPD_TGT_CAN2;
            else if (can_any) tgt = xpd_pkg::XPD_TGT_CAN1;
         end else if (in_range(cpu_addr, xpd_pkg::RTC_LO, xpd_pkg::RTC_HI)) begin
            if (eff_en[xpd_pkg::BIT_RTC] || can_any) tgt = xpd_pkg::XPD_TGT_RTC;
         end
      end
      if (tgt == xpd_pkg::XPD_TGT_CAN1 || tgt == xpd_pkg::XPD_TGT_CAN2) begin
         ws_nxt = xpd_pkg::CAN_WAIT_STATES;
      end
      // Pin release: bits 0..3 are P4.4..P4.7
      rel_nxt[0] = !(global_en_r && eff_en[xpd_pkg::BIT_CAN2]);
      rel_nxt[1] = !(global_en_r && eff_en[xpd_pkg::BIT_CAN1]);
      rel_nxt[2] = rel_nxt[1];
      rel_nxt[3] = rel_nxt[0];
      seg_nxt = (global_en_r && can_any) ? xpd_pkg::SEG_LINES_CAN
                                          : xpd_pkg::SEG_LINES_FULL;
      osc_nxt = power_down_req &&
                (!eff_en[xpd_pkg::BIT_RTC] || osc_off_r);
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_ext_r <= 1'b0;
         sel_lower_ram_r <= 1'b0;
         sel_upper_ram_r <= 1'b0;
         sel_can1_r <= 1'b0;
         sel_can2_r <= 1'b0;
         sel_rtc_r <= 1'b0;
         wait_states_r <= 2'h0;
         byte_access_r <= 1'b0;
         p4_gpio_release_r <= 4'hf;
         seg_lines_r <= xpd_pkg::SEG_LINES_FULL;
         osc_stop_r <= 1'b0;
      end else if (clk_en) begin
         sel_ext_r <= cpu_req && (tgt == xpd_pkg::XPD_TGT_EXT);
         sel_lower_ram_r <= cpu_req && (tgt == xpd_pkg::XPD_TGT_LOWER_RAM);
         sel_upper_ram_r <= cpu_req && (tgt == xpd_pkg::XPD_TGT_UPPER_RAM);
         sel_can1_r <= cpu_req && (tgt == xpd_pkg::XPD_TGT_CAN1);
         sel_can2_r <= cpu_req && (tgt == xpd_pkg::XPD_TGT_CAN2);
         sel_rtc_r <= cpu_req && (tgt == xpd_pkg::XPD_TGT_RTC);
         wait_states_r <= cpu_req ? ws_nxt : 2'h0;
         byte_access_r <= cpu_req && cpu_byte;
         p4_gpio_release_r <= rel_nxt;
         seg_lines_r <= seg_nxt;
         osc_stop_r <= osc_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_one_target;
      @(posedge core_clk) disable iff (!rst_n)
      $past(cpu_req) && $past(clk_en) |-> $onehot({sel_ext_r, sel_lower_ram_r, sel_upper_ram_r,
                                          sel_can1_r, sel_can2_r, sel_rtc_r});
   endproperty
   a_one_target: assert property (p_one_target) else $error("Not one target");
   property p_lower_ram_off;
      @(posedge core_clk) disable iff (!rst_n)
      sel_lower_ram_r |-> $past(global_en_r || emu_mode);
   endproperty
   a_lower_ram_off: assert property (p_lower_ram_off) else $error("Lower RAM off");
   property p_upper_ram_off;
      @(posedge core_clk) disable iff (!rst_n)
      sel_upper_ram_r |-> $past((global_en_r || emu_mode) && eff_en[xpd_pkg::BIT_UPPER_RAM]);
   endproperty
   a_upper_ram_off: assert property (p_upper_ram_off) else $error("Upper RAM off");
   property p_ext_off;
      @(posedge core_clk) disable iff (!rst_n)
      $past(cpu_req && clk_en && !global_en_r && !emu_mode) |-> sel_ext_r;
   endproperty
   a_ext_off: assert property (p_ext_off) else $error("Not routed external");
   property p_can1_en;
      @(posedge core_clk) disable iff (!rst_n)
      sel_can1_r |-> $past(eff_en[xpd_pkg::BIT_CAN1]);
   endproperty
   a_can1_en: assert property (p_can1_en) else $error("First CAN not enabled");
   property p_can2_en;
      @(posedge core_clk) disable iff (!rst_n)
      sel_can2_r |-> $past(eff_en[xpd_pkg::BIT_CAN2]);
   endproperty
   a_can2_en: assert property (p_can2_en) else $error("Second CAN not enabled");
   property p_rtc_en;
      @(posedge core_clk) disable iff (!rst_n)
      sel_rtc_r |-> $past(eff_en[xpd_pkg::BIT_RTC] || can_any);
   endproperty
   a_rtc_en: assert property (p_rtc_en) else $error("Calendar range taken");
   property p_pin_first;
      @(posedge core_clk) disable iff (!rst_n)
      !p4_gpio_release_r[1] |-> $past(eff_en[xpd_pkg::BIT_CAN1]);
   endproperty
   a_pin_first: assert property (p_pin_first) else $error("First CAN pins held");
   property p_pin_second;
      @(posedge core_clk) disable iff (!rst_n)
      !p4_gpio_release_r[0] |-> $past(eff_en[xpd_pkg::BIT_CAN2]);
   endproperty
   a_pin_second: assert property (p_pin_second) else $error("Second CAN pins held");
   property p_osc;
      @(posedge core_clk) disable iff (!rst_n)
      osc_stop_r |-> $past(power_down_req);
   endproperty
   a_osc: assert property (p_osc) else $error("Oscillator stopped while running");
   property p_freeze;
      @(posedge core_clk) disable iff (!rst_n)
      !clk_en |=> $stable(periph_en_r) && $stable(sel_ext_r);
   endproperty
   a_freeze: assert property (p_freeze) else $error("State moved while frozen");
   property p_lock;
      @(posedge core_clk) disable iff (!rst_n)
      global_en_r && !$changed(global_en_r) |=> $stable(periph_en_r);
   endproperty
   a_lock: assert property (p_lock) else $error("Enable changed while locked");
   property p_can_wait;
      @(posedge core_clk) disable iff (!rst_n)
      sel_can1_r || sel_can2_r |-> wait_states_r == xpd_pkg::CAN_WAIT_STATES;
   endproperty
   a_can_wait: assert property (p_can_wait) else $error("CAN wait states wrong");
   property p_xram_wait;
      @(posedge core_clk) disable iff (!rst_n)
      sel_lower_ram_r || sel_upper_ram_r |-> wait_states_r == xpd_pkg::XRAM_WAIT_STATES;
   endproperty
   a_xram_wait: assert property (p_xram_wait) else $error("RAM wait states wrong");
   property p_seg;
      @(posedge core_clk) disable iff (!rst_n)
      (sel_can1_r || sel_can2_r) && !emu_mode |-> seg_lines_r == xpd_pkg::SEG_LINES_CAN;
   endproperty
   a_seg: assert property (p_seg) else $error("Segment lines not limited");
   property p_bresp;
      @(posedge core_clk) disable iff (!rst_n)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bresp: assert property (p_bresp) else $error("Write response dropped");
   property p_rvalid;
      @(posedge core_clk) disable iff (!rst_n)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rvalid: assert property (p_rvalid) else $error("Read data dropped");
   c_can1: cover property (@(posedge core_clk) sel_can1_r);
   c_upper_ram: cover property (@(posedge core_clk) sel_upper_ram_r);
   c_ext: cover property (@(posedge core_clk) sel_ext_r ##1 sel_rtc_r);
   c_lock: cover property (@(posedge core_clk) $rose(global_en_r));
endmodule : xpd_decode
`default_nettype wire

// ==== src/xpd_pkg.sv ====
// Purpose: Constants for the extension bus peripheral decoder
// Assumes: 20 MHz core clock, AXI4-Lite register access
// Notes: Address ranges are full 24-bit byte addresses
package xpd_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [15:0] OFS_PERIPH_ENABLE = 16'hf024;
   localparam logic [15:0] OFS_SYS_CONFIG = 16'hf028;
   localparam logic [15:0] OFS_STATUS = 16'hf02c;
   localparam logic [15:0] RST_PERIPH_ENABLE = 16'h0005;
   localparam logic [4:0] EMU_ALL_ENABLED = 5'h1f;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int BIT_CAN1 = 0;
   localparam int BIT_CAN2 = 1;
   localparam int BIT_LOWER_RAM = 2;
   localparam int BIT_UPPER_RAM = 3;
   localparam int BIT_RTC = 4;
   localparam int BIT_GLOBAL_EN = 2;
   localparam int BIT_CAL_OSC_OFF = 0;
   // ----------------------------------------------------------------
   // Address ranges
   // ----------------------------------------------------------------
   localparam logic [23:0] LOWER_RAM_LO = 24'h00e000;
   localparam logic [23:0] LOWER_RAM_HI = 24'h00e7ff;
   localparam logic [23:0] UPPER_RAM_LO = 24'h00c000;
   localparam logic [23:0] UPPER_RAM_HI = 24'h00dfff;
   localparam logic [23:0] CAN1_LO = 24'h00ef00;
   localparam logic [23:0] CAN1_HI = 24'h00efff;
   localparam logic [23:0] CAN2_LO = 24'h00ee00;
   localparam logic [23:0] CAN2_HI = 24'h00eeff;
   localparam logic [23:0] RTC_LO = 24'h00ec00;
   localparam logic [23:0] RTC_HI = 24'h00ecff;
   // ----------------------------------------------------------------
   // Timing and segment lines
   // ----------------------------------------------------------------
   localparam logic [1:0] XRAM_WAIT_STATES = 2'h0;
   localparam logic [1:0] CAN_WAIT_STATES = 2'h2;
   localparam logic [3:0] SEG_LINES_CAN = 4'h4;
   localparam logic [3:0] SEG_LINES_FULL = 4'h8;
   // ----------------------------------------------------------------
   // Targets
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      XPD_TGT_EXT,
      XPD_TGT_LOWER_RAM,
      XPD_TGT_UPPER_RAM,
      XPD_TGT_CAN1,
      XPD_TGT_CAN2,
      XPD_TGT_RTC
   } xpd_target_e;
endpackage : xpd_pkg

// ==== verification/xpd_cpu_model.sv ====
// Purpose: CPU side model issuing decode requests
// Assumes: Requests launched just after a rising edge
// Notes: Idle address shows the inverse of the last one
`timescale 1ns/1ps
`default_nettype none
module xpd_cpu_model (
   // Clock
   input wire logic core_clk,
   // CPU access
   output logic cpu_req,
   output logic [23:0] cpu_addr,
   output logic cpu_byte
);
   // Plain data accesses only, no stack or bit access
   initial begin
      cpu_req = 1'b0;
      cpu_addr = 24'h000000;
      cpu_byte = 1'b0;
   end
   task automatic acc(input logic [23:0] a, input logic b);
      @(posedge core_clk);
      cpu_req <= 1'b1;
      cpu_addr <= a;
      cpu_byte <= b;
      @(posedge core_clk);
      cpu_req <= 1'b0;
      cpu_addr <= ~a;
      cpu_byte <= ~b;
   endtask : acc
endmodule : xpd_cpu_model
`default_nettype wire

// ==== verification/tb.sv ====
// Purpose: Self-checking bench for the extension bus decoder
// Assumes: AXI4-Lite master and CPU model driven just after edges
// Notes: Expected results queued, compared by a monitor
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic core_clk, rst_n, clk_en, emu_mode, power_down_req;
   logic cpu_req, cpu_byte;
   logic [23:0] cpu_addr;
   logic sel_ext_r, sel_lower_ram_r, sel_upper_ram_r, sel_can1_r, sel_can2_r;
   logic sel_rtc_r, byte_access_r, osc_stop_r;
   logic [1:0] wait_states_r, s_axi_bresp, s_axi_rresp;
   logic [3:0] p4_gpio_release_r, seg_lines_r, s_axi_wstrb;
   logic [15:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [33:0] dq[$];
   logic [33:0] rq[$];
   int num_errors = 0;
   int cmp_count = 0;
   localparam logic [5:0] EXT = 6'h20, X1 = 6'h10, X2 = 6'h08;
   localparam logic [5:0] C1 = 6'h04, C2 = 6'h02, RT = 6'h01;
   localparam logic [15:0] PE = xpd_pkg::OFS_PERIPH_ENABLE;
   localparam logic [15:0] ST = xpd_pkg::OFS_STATUS;

   xpd_decode i_xpd_decode (.core_clk, .rst_n, .clk_en, .emu_mode, .power_down_req,
      .cpu_req, .cpu_addr, .cpu_byte, .sel_ext_r, .sel_lower_ram_r, .sel_upper_ram_r,
      .sel_can1_r, .sel_can2_r, .sel_rtc_r, .wait_states_r, .byte_access_r,
      .p4_gpio_release_r, .seg_lines_r, .osc_stop_r, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   xpd_cpu_model i_xpd_cpu_model (.core_clk, .cpu_req, .cpu_addr, .cpu_byte);

   // ----------------------------------------------------------------
   // Checking
   // ----------------------------------------------------------------
   task cmp(input logic [33:0] got, input logic [33:0] exp);
      cmp_count++;
      if (got !== exp) begin
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         num_errors++;
      end
   endtask : cmp
   task tally_and_finish;
      if (num_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   always @(posedge core_clk) begin
      if (sel_ext_r | sel_lower_ram_r | sel_upper_ram_r | sel_can1_r | sel_can2_r
         | sel_rtc_r) begin
         if (dq.size() == 0) cmp(34'h1, 34'h0);
         else cmp({25'h0, sel_ext_r, sel_lower_ram_r, sel_upper_ram_r, sel_can1_r, sel_can2_r,
            sel_rtc_r, wait_states_r, byte_access_r}, dq.pop_front());
      end
      if (s_axi_bvalid && s_axi_bready) cmp({32'h0, s_axi_bresp}, 34'h0);
      if (s_axi_rvalid && s_axi_rready) begin
         if (rq.size() == 0) cmp(34'h1, 34'h0);
         else cmp({s_axi_rresp, s_axi_rdata}, rq.pop_front());
      end
   end

   // ----------------------------------------------------------------
   // Stimulus
   // ----------------------------------------------------------------
   task wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'($urandom);
      do begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
      end while (!(s_axi_bvalid && s_axi_bready));
      s_axi_bready <= 1'b0;
   endtask : wr
   task rd(input logic [15:0] a, input logic [33:0] exp);
      rq.push_back(exp);
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'($urandom);
      do begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
      end while (!(s_axi_rvalid && s_axi_rready));
      s_axi_rready <= 1'b0;
   endtask : rd
   task chk(input logic [23:0] base, input logic [5:0] s);
      logic b;
      logic [23:0] a;
      b = 1'($urandom);
      a = base | 24'($urandom & 32'hff);
      dq.push_back({25'h0, s, (s[2] | s[1]) ? 2'h2 : 2'h0, b});
      i_xpd_cpu_model.acc(a, b);
   endtask : chk
   task rst;
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
   endtask : rst
   task ph(input logic [4:0] en);
      rst();
      wr(PE, {27'h0, en});
      wr(xpd_pkg::OFS_SYS_CONFIG, 32'h4);
   endtask : ph

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   initial begin
      #100us;
      num_errors++;
      tally_and_finish();
   end
   initial begin
      int seed;
      seed = $urandom(32'hb9b5);
      {rst_n, emu_mode, power_down_req, s_axi_awvalid, s_axi_wvalid} = 5'h0;
      {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
      clk_en = 1'b1;
      s_axi_wstrb = 4'hf;
      s_axi_awaddr = 16'h0;
      s_axi_araddr = 16'h0;
      s_axi_wdata = 32'h0;
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(PE, {2'h0, 32'h5});
      rd(16'h0000, {2'h2, 32'h0});
      chk(24'h00e000, EXT);
      chk(24'h00ef00, EXT);
      cmp({30'h0, p4_gpio_release_r}, {30'h0, 4'hf});
      ph(5'h1a);
      wr(PE, 32'h5);
      rd(PE, {2'h0, 32'h1a});
      chk(24'h00e000, EXT);
      chk(24'h00c000, X2);
      chk(24'h00ef00, C2);
      chk(24'h00ee00, C2);
      chk(24'h00ec00, RT);
      cmp({30'h0, p4_gpio_release_r}, {30'h0, 4'h6});
      rd(ST, {2'h0, 32'h20});
      ph(5'h05);
      chk(24'h00e000, X1);
      chk(24'h00c000, EXT);
      chk(24'h00ef00, C1);
      chk(24'h00ee00, C1);
      cmp({30'h0, p4_gpio_release_r}, {30'h0, 4'h9});
      ph(5'h00);
      chk(24'h00ee00, EXT);
      chk(24'h00ef00, EXT);
      chk(24'h00ec00, EXT);
      power_down_req <= 1'b1;
      rd(ST, {2'h0, 32'hc0});
      power_down_req <= 1'b0;
      emu_mode <= 1'b1;
      rd(PE, {2'h0, 32'h1f});
      chk(24'h00c000, X2);
      @(posedge core_clk);
      clk_en <= 1'b0;
      i_xpd_cpu_model.acc(24'h00c000, 1'b0);
      clk_en <= 1'b1;
      repeat (4) @(posedge core_clk);
      cmp(34'(dq.size() + rq.size()), 34'h0);
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
